/* common/trail_pkg.sv */
// shared frame layout and alarm constants for the trail supervision block
package trail_pkg;
	typedef logic [7:0] octet_type;
	// byte positions inside one frame
	localparam logic [7:0] CODE_IDX = 8'h00;
	localparam logic [7:0] K2_IDX = 8'h01;
	localparam logic [7:0] H1_IDX = 8'h02;
	localparam logic [7:0] H2_IDX = 8'h03;
	localparam logic [7:0] REMOTE_IDX = 8'h04;
	// alarm patterns and fields
	localparam octet_type ALL_ONES = 8'hff;
	localparam logic [2:0] K2_ALARM_CODE = 3'h7;
	localparam octet_type K2_NORMAL = 8'h00;
	localparam int RDI_BIT = 7;
	localparam int REI_W = 4;
	localparam logic [2:0] REMOTE_SPARE = 3'h0;
	// reset values
	localparam octet_type OCTET_RESET = 8'h00;
	localparam logic [REI_W-1:0] REI_RESET = 4'h0;
endpackage

/* common/byte_stream_if.sv */
// byte stream with frame start, shared between the trail modules
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
	logic [7:0] data;
	logic sof;
	logic valid;
	modport src (output data, output sof, output valid);
	modport snk (input data, input sof, input valid);
endinterface
`default_nettype wire

/* design/event_counter.sv */
// saturating accumulator for error and violation counts
`timescale 1ns/1ps
`default_nettype none
module event_counter #(
	parameter int W = 16,
	parameter int INC_W = 4
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // async reset, high
	input wire logic add_en, // add this cycle
	input wire logic [INC_W-1:0] add_val, // amount to add
	output logic [W-1:0] count // running total
);
	logic [W:0] next_sum;
	localparam logic [W-1:0] FULL = '1;

	assign next_sum = {1'b0, count} + {{(W+1-INC_W){1'b0}}, add_val};

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
		end else if (add_en) begin
			count <= next_sum[W] ? FULL : next_sum[W-1:0];
		end
	end

	property p_no_wrap;
		@(posedge clk_sys) disable iff (sys_rst)
		count == FULL |=> count == FULL;
	endproperty
	a_no_wrap: assert property (p_no_wrap) else $error("counter wrapped");
endmodule
`default_nettype wire

/* design/code_monitor.sv */
// running bit-interleaved parity with check against the carried code byte
`timescale 1ns/1ps
`default_nettype none
module code_monitor (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // async reset, high
	byte_stream_if.snk strm, // observed stream, never altered
	output logic [7:0] code, // parity of bytes so far in frame
	output logic checked, // pulse: one frame checked
	output logic [3:0] violations // mismatching bits of last check
);
	logic primed;
	logic [7:0] diff;
	logic [3:0] ones;

	assign diff = strm.data ^ code;

	always_comb begin
		ones = 4'h0;
		for (int i = 0; i < 8; i++) begin
			ones = ones + {3'h0, diff[i]};
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			code <= trail_pkg::OCTET_RESET;
		end else if (strm.valid) begin
			code <= strm.sof ? strm.data : (code ^ strm.data);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			primed <= 1'b0;
			checked <= 1'b0;
			violations <= trail_pkg::REI_RESET;
		end else begin
			checked <= strm.valid && strm.sof && primed;
			if (strm.valid && strm.sof) begin
				primed <= 1'b1;
				if (primed) begin
					violations <= ones;
				end
			end
		end
	end

	property p_clean_check;
		@(posedge clk_sys) disable iff (sys_rst)
		strm.valid && strm.sof && primed && diff == 8'h00
			|=> checked && violations == 4'h0;
	endproperty
	a_clean_check: assert property (p_clean_check)
		else $error("clean frame flagged");
endmodule
`default_nettype wire

/* design/trail_supervision.sv */
// trail termination sink and source with alarm insertion and remote report
`timescale 1ns/1ps
`default_nettype none
module trail_supervision #(
	parameter int FRAME_LEN = 32,
	parameter logic [7:0] TRIB_FIRST = 8'h08,
	parameter logic [7:0] TRIB_LAST = 8'h0b,
	parameter logic [7:0] PTR_H1 = 8'h60,
	parameter logic [7:0] PTR_H2 = 8'h00,
	parameter int ERR_W = 16
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // async reset, high
	input wire logic [7:0] rx_data, // received frame byte
	input wire logic rx_sof, // first byte of received frame
	input wire logic rx_valid, // received byte present
	input wire logic loss_of_frame_defect, // framer lost alignment
	input wire logic [7:0] tap_data, // upstream link connection tap
	input wire logic tap_sof, // tap frame start
	input wire logic tap_valid, // tap byte present
	input wire logic [7:0] tx_payload, // payload to send
	input wire logic tx_alarm_in, // payload input carries all ones
	input wire logic tx_ssf_in, // server signal fail with payload
	input wire logic trib_alarm_in, // tributary slot carries all ones
	input wire logic through_connect, // sink output feeds the source
	input wire logic pdh_full_alarm, // send whole line as all ones
	output logic [7:0] rx_out_data, // sink data toward client
	output logic rx_out_sof, // sink frame start
	output logic rx_out_valid, // sink byte present
	output logic server_signal_fail, // sink output is alarm
	output logic ms_alarm_defect, // alarm seen in protection byte
	output logic admin_unit_alarm_defect, // alarm seen in pointer
	output logic loss_of_pointer, // pointer neither valid nor alarm
	output logic tandem_unavailable, // idle tandem not available
	output logic near_end_defect, // local defect status
	output logic [ERR_W-1:0] near_end_errors, // local code violations
	output logic far_end_defect, // remote defect received
	output logic [ERR_W-1:0] far_end_errors, // remote error total
	output logic code_violation, // pulse: frame had mismatches
	output logic tap_violation, // pulse: tap frame had mismatches
	output logic fault_located, // fault between tap and sink
	output logic [7:0] tx_data, // transmitted frame byte
	output logic tx_sof // first byte of transmitted frame
);
	localparam logic [7:0] LAST_IDX = 8'(FRAME_LEN - 1);

	byte_stream_if rx_strm ();
	byte_stream_if tap_strm ();
	byte_stream_if tx_strm ();

	logic [7:0] rx_idx;
	logic [7:0] rx_pos;
	logic [7:0] h1_seen;
	logic local_alarm;
	logic rx_checked;
	logic [3:0] rx_viol;
	logic [7:0] rx_code;
	logic tap_checked;
	logic [3:0] tap_viol;
	logic tap_bad;
	logic line_bad;
	logic [trail_pkg::REI_W-1:0] rei_hold;
	logic fe_add;
	logic [7:0] tx_idx;
	logic [7:0] tx_code;
	logic src_alarm;
	logic [7:0] src_payload;
	logic in_trib;
	logic [7:0] next_tx;

	assign rx_strm.data = rx_data;
	assign rx_strm.sof = rx_sof;
	assign rx_strm.valid = rx_valid;
	assign tap_strm.data = tap_data;
	assign tap_strm.sof = tap_sof;
	assign tap_strm.valid = tap_valid;
	assign tx_strm.data = tx_data;
	assign tx_strm.sof = tx_sof;
	assign tx_strm.valid = 1'b1;

	// sink side: position of the current byte within its frame
	assign rx_pos = rx_sof ? trail_pkg::CODE_IDX : rx_idx;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_idx <= trail_pkg::CODE_IDX;
		end else if (rx_valid) begin
			if (rx_sof) begin
				rx_idx <= 8'h01;
			end else if (rx_idx != 8'hff) begin
				rx_idx <= rx_idx + 8'h01;
			end
		end
	end

	// code check on the received stream
	code_monitor u_rx_check (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.strm(rx_strm),
		.code(rx_code),
		.checked(rx_checked),
		.violations(rx_viol)
	);

	// non-intrusive monitor at the end of the upstream link connection
	code_monitor u_tap_check (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.strm(tap_strm),
		.code(),
		.checked(tap_checked),
		.violations(tap_viol)
	);

	// overhead byte detectors, each refreshed once per frame
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ms_alarm_defect <= 1'b0;
			h1_seen <= trail_pkg::OCTET_RESET;
			admin_unit_alarm_defect <= 1'b0;
			loss_of_pointer <= 1'b0;
		end else if (rx_valid) begin
			if (rx_pos == trail_pkg::K2_IDX) begin
				ms_alarm_defect <= rx_data[2:0] == trail_pkg::K2_ALARM_CODE;
			end
			if (rx_pos == trail_pkg::H1_IDX) begin
				h1_seen <= rx_data;
			end
			if (rx_pos == trail_pkg::H2_IDX) begin
				admin_unit_alarm_defect <= h1_seen == trail_pkg::ALL_ONES
					&& rx_data == trail_pkg::ALL_ONES;
				loss_of_pointer <= !(h1_seen == trail_pkg::ALL_ONES
					&& rx_data == trail_pkg::ALL_ONES)
					&& !(h1_seen == PTR_H1 && rx_data == PTR_H2);
			end
		end
	end

	// framer loss of frame plus the protection and pointer alarms found here trigger insertion; loss of pointer does not
	assign local_alarm = loss_of_frame_defect || ms_alarm_defect
		|| admin_unit_alarm_defect;

	// all-ones replacement of every byte while a defect lasts
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_out_data <= trail_pkg::OCTET_RESET;
			rx_out_sof <= 1'b0;
			rx_out_valid <= 1'b0;
			server_signal_fail <= 1'b0;
		end else begin
			rx_out_data <= local_alarm ? trail_pkg::ALL_ONES : rx_data;
			rx_out_sof <= rx_sof;
			rx_out_valid <= rx_valid;
			server_signal_fail <= local_alarm;
		end
	end

	// near-end and far-end performance kept apart
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			near_end_defect <= 1'b0;
			far_end_defect <= 1'b0;
			tandem_unavailable <= 1'b0;
		end else begin
			near_end_defect <= local_alarm;
			tandem_unavailable <= loss_of_pointer || admin_unit_alarm_defect;
			if (rx_valid && rx_pos == trail_pkg::REMOTE_IDX) begin
				far_end_defect <= rx_data[trail_pkg::RDI_BIT];
			end
		end
	end

	assign fe_add = rx_valid && rx_pos == trail_pkg::REMOTE_IDX;

	event_counter #(.W(ERR_W), .INC_W(4)) u_ne_count (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.add_en(rx_checked),
		.add_val(rx_viol),
		.count(near_end_errors)
	);

	event_counter #(.W(ERR_W), .INC_W(4)) u_fe_count (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.add_en(fe_add),
		.add_val(rx_data[trail_pkg::REI_W-1:0]),
		.count(far_end_errors)
	);

	// per-frame verdicts for fault localisation
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			code_violation <= 1'b0;
			tap_violation <= 1'b0;
			line_bad <= 1'b0;
			tap_bad <= 1'b0;
			fault_located <= 1'b0;
			rei_hold <= trail_pkg::REI_RESET;
		end else begin
			code_violation <= rx_checked && rx_viol != 4'h0;
			tap_violation <= tap_checked && tap_viol != 4'h0;
			if (rx_checked) begin
				line_bad <= rx_viol != 4'h0;
				rei_hold <= rx_viol;
			end
			if (tap_checked) begin
				tap_bad <= tap_viol != 4'h0;
			end
			fault_located <= line_bad && !tap_bad;
		end
	end

	// source side: free-running frame position
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_idx <= trail_pkg::CODE_IDX;
		end else begin
			tx_idx <= (tx_idx == LAST_IDX) ? trail_pkg::CODE_IDX
				: tx_idx + 8'h01;
		end
	end

	// parity of what actually leaves, alarms included
	code_monitor u_tx_code (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.strm(tx_strm),
		.code(tx_code),
		.checked(),
		.violations()
	);

	// through connection turns the sink alarm into the pointer alarm
	assign src_alarm = through_connect ? server_signal_fail
		: (tx_alarm_in && tx_ssf_in);
	assign src_payload = through_connect ? rx_out_data : tx_payload;
	assign in_trib = tx_idx >= TRIB_FIRST && tx_idx <= TRIB_LAST;

	always_comb begin
		next_tx = src_payload;
		case (tx_idx)
			trail_pkg::CODE_IDX: begin
				next_tx = tx_code ^ tx_data;
			end
			trail_pkg::K2_IDX: begin
				next_tx = trail_pkg::K2_NORMAL;
			end
			trail_pkg::H1_IDX: begin
				next_tx = src_alarm ? trail_pkg::ALL_ONES : PTR_H1;
			end
			trail_pkg::H2_IDX: begin
				next_tx = src_alarm ? trail_pkg::ALL_ONES : PTR_H2;
			end
			trail_pkg::REMOTE_IDX: begin
				next_tx = {near_end_defect, trail_pkg::REMOTE_SPARE, rei_hold};
			end
			default: begin
				if (src_alarm || (trib_alarm_in && in_trib)) begin
					next_tx = trail_pkg::ALL_ONES;
				end
			end
		endcase
		if (pdh_full_alarm) begin
			next_tx = trail_pkg::ALL_ONES;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_data <= trail_pkg::OCTET_RESET;
			tx_sof <= 1'b0;
		end else begin
			tx_data <= next_tx;
			tx_sof <= tx_idx == trail_pkg::CODE_IDX;
		end
	end

	property p_alarm_fill;
		@(posedge clk_sys) disable iff (sys_rst)
		local_alarm |=> rx_out_data == trail_pkg::ALL_ONES;
	endproperty
	a_alarm_fill: assert property (p_alarm_fill)
		else $error("alarm not filled with ones");

	property p_release;
		@(posedge clk_sys) disable iff (sys_rst)
		!local_alarm |=> rx_out_data == $past(rx_data) && !server_signal_fail;
	endproperty
	a_release: assert property (p_release)
		else $error("data not released after defect");

	property p_ssf_tracks;
		@(posedge clk_sys) disable iff (sys_rst)
		server_signal_fail |-> rx_out_data == trail_pkg::ALL_ONES;
	endproperty
	a_ssf_tracks: assert property (p_ssf_tracks)
		else $error("server fail without alarm data");

	property p_lof;
		@(posedge clk_sys) disable iff (sys_rst)
		loss_of_frame_defect |=> server_signal_fail ##0 near_end_defect;
	endproperty
	a_lof: assert property (p_lof)
		else $error("loss of frame not alarmed");

	property p_k2;
		@(posedge clk_sys) disable iff (sys_rst)
		rx_valid && rx_pos == trail_pkg::K2_IDX && rx_data[2:0] == 3'h7
			|=> ms_alarm_defect ##1 server_signal_fail;
	endproperty
	a_k2: assert property (p_k2)
		else $error("protection byte alarm missed");

	property p_pointer;
		@(posedge clk_sys) disable iff (sys_rst)
		rx_valid && rx_pos == trail_pkg::H2_IDX && h1_seen == 8'hff
			&& rx_data == 8'hff |=> admin_unit_alarm_defect && !loss_of_pointer;
	endproperty
	a_pointer: assert property (p_pointer)
		else $error("pointer alarm missed");

	property p_rdi;
		@(posedge clk_sys) disable iff (sys_rst)
		tx_idx == trail_pkg::REMOTE_IDX && !pdh_full_alarm
			|=> tx_data[7] == $past(near_end_defect)
			&& tx_data[3:0] == $past(rei_hold);
	endproperty
	a_rdi: assert property (p_rdi)
		else $error("remote indicator byte wrong");

	property p_au_alarm;
		@(posedge clk_sys) disable iff (sys_rst)
		tx_idx == trail_pkg::H1_IDX && src_alarm
			|=> tx_data == 8'hff ##1 tx_data == 8'hff || $past(pdh_full_alarm);
	endproperty
	a_au_alarm: assert property (p_au_alarm)
		else $error("admin unit alarm not sent");

	property p_k2_valid;
		@(posedge clk_sys) disable iff (sys_rst)
		tx_idx == trail_pkg::K2_IDX && !pdh_full_alarm
			|=> tx_data == trail_pkg::K2_NORMAL;
	endproperty
	a_k2_valid: assert property (p_k2_valid)
		else $error("section overhead lost under alarm");
endmodule
`default_nettype wire

/* verif/far_end_source.sv */
// far-end trail source model that feeds frames into the receive stream
`timescale 1ns/1ps
`default_nettype none
module far_end_source #(
	parameter int FRAME_LEN = 32,
	parameter logic [7:0] PTR_H1 = 8'h60,
	parameter logic [7:0] PTR_H2 = 8'h00
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // sync reset, high
	input wire logic run, // send frames
	input wire logic [7:0] err_mask, // bits flipped in the code byte
	input wire logic k2_alarm, // alarm code in protection byte
	input wire logic [1:0] ptr_mode, // 0 normal, 1 all ones, 2 invalid
	input wire logic remote_defect_indicator, // remote defect bit to send
	input wire logic [3:0] remote_error_indicator, // remote error count to send
	output logic [7:0] rx_data, // frame byte
	output logic rx_sof, // frame start
	output logic rx_valid // byte present
);
	int pos;
	logic [7:0] par;
	logic [7:0] prev;
	logic [7:0] b;
	initial begin
		rx_data = 8'h00;
		rx_sof = 1'b0;
		rx_valid = 1'b0;
		pos = 0;
		par = 8'h00;
		prev = 8'h00;
	end
	always @(posedge clk_sys) begin
		#1;
		if (sys_rst || !run) begin
			// released line shows the inverse, not the last byte
			rx_valid = 1'b0;
			rx_sof = 1'b0;
			rx_data = ~rx_data;
			pos = 0;
			prev = 8'h00;
		end else begin
			case (pos)
				0: b = prev ^ err_mask;
				1: b = k2_alarm ? 8'h07 : 8'h00;
				2: b = (ptr_mode == 2'h1) ? 8'hff
					: ((ptr_mode == 2'h2) ? 8'h12 : PTR_H1);
				3: b = (ptr_mode == 2'h1) ? 8'hff
					: ((ptr_mode == 2'h2) ? 8'h34 : PTR_H2);
				4: b = {remote_defect_indicator, 3'h0, remote_error_indicator};
				default: b = 8'(pos);
			endcase
			rx_data = b;
			rx_sof = (pos == 0);
			rx_valid = 1'b1;
			par = (pos == 0) ? b : (par ^ b);
			if (pos == FRAME_LEN - 1) begin
				prev = par;
				pos = 0;
			end else begin
				pos++;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the trail supervision block
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int FL = 32;
	localparam logic [7:0] H1 = 8'h60;
	localparam logic [7:0] H2 = 8'h00;
	localparam logic [7:0] TF = 8'h08;
	localparam logic [7:0] TL = 8'h0b;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic run = 1'b0;
	logic [7:0] err_mask = 8'h00;
	logic [7:0] tap_err_mask = 8'h00;
	logic k2_alarm = 1'b0;
	logic [1:0] ptr_mode = 2'h0;
	logic remote_defect_indicator = 1'b0;
	logic [3:0] remote_error_indicator = 4'h0;
	logic loss_of_frame_defect = 1'b0;
	logic [7:0] tx_payload = 8'h5a;
	logic tx_alarm_in = 1'b0;
	logic tx_ssf_in = 1'b0;
	logic trib_alarm_in = 1'b0;
	logic through_connect = 1'b0;
	logic pdh_full_alarm = 1'b0;
	logic [7:0] rx_data, tap_data, rx_out_data, tx_data;
	logic rx_sof, rx_valid, tap_sof, tap_valid, tx_sof;
	logic rx_out_sof, rx_out_valid;
	logic server_signal_fail, ms_alarm_defect, admin_unit_alarm_defect;
	logic loss_of_pointer, tandem_unavailable, near_end_defect;
	logic far_end_defect, code_violation, tap_violation, fault_located;
	logic [15:0] near_end_errors, far_end_errors;
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] fa [FL];
	logic [7:0] fb [FL];

	always #12.5 clk_sys = ~clk_sys;

	trail_supervision #(.FRAME_LEN(FL), .TRIB_FIRST(TF), .TRIB_LAST(TL),
		.PTR_H1(H1), .PTR_H2(H2), .ERR_W(16)) u_trail_supervision (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .rx_data(rx_data),
		.rx_sof(rx_sof), .rx_valid(rx_valid),
		.loss_of_frame_defect(loss_of_frame_defect), .tap_data(tap_data),
		.tap_sof(tap_sof), .tap_valid(tap_valid), .tx_payload(tx_payload),
		.tx_alarm_in(tx_alarm_in), .tx_ssf_in(tx_ssf_in),
		.trib_alarm_in(trib_alarm_in), .through_connect(through_connect),
		.pdh_full_alarm(pdh_full_alarm), .rx_out_data(rx_out_data),
		.rx_out_sof(rx_out_sof), .rx_out_valid(rx_out_valid),
		.server_signal_fail(server_signal_fail),
		.ms_alarm_defect(ms_alarm_defect),
		.admin_unit_alarm_defect(admin_unit_alarm_defect),
		.loss_of_pointer(loss_of_pointer),
		.tandem_unavailable(tandem_unavailable),
		.near_end_defect(near_end_defect), .near_end_errors(near_end_errors),
		.far_end_defect(far_end_defect), .far_end_errors(far_end_errors),
		.code_violation(code_violation), .tap_violation(tap_violation),
		.fault_located(fault_located), .tx_data(tx_data), .tx_sof(tx_sof));

	far_end_source #(.FRAME_LEN(FL), .PTR_H1(H1), .PTR_H2(H2))
	u_far_end_source (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(run),
		.err_mask(err_mask), .k2_alarm(k2_alarm), .ptr_mode(ptr_mode),
		.remote_defect_indicator(remote_defect_indicator), .remote_error_indicator(remote_error_indicator), .rx_data(rx_data), .rx_sof(rx_sof),
		.rx_valid(rx_valid));

	// clean upstream tap: the fault must lie between tap and sink
	far_end_source #(.FRAME_LEN(FL), .PTR_H1(H1), .PTR_H2(H2))
	u_far_end_source_tap (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(run),
		.err_mask(tap_err_mask), .k2_alarm(1'b0), .ptr_mode(2'h0), .remote_defect_indicator(remote_defect_indicator),
		.remote_error_indicator(4'h0), .rx_data(tap_data), .rx_sof(tap_sof),
		.rx_valid(tap_valid));

	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_frames(input int n);
		repeat (n * FL) tick();
	endtask

	// capture two whole transmit frames from a frame start
	task automatic cap_tx;
		int i;
		int n;
		n = 0;
		while (tx_sof !== 1'b1 && n < 2 * FL) begin
			tick();
			n++;
		end
		for (i = 0; i < 2 * FL; i++) begin
			if (i < FL) begin
				fa[i] = tx_data;
			end else begin
				fb[i - FL] = tx_data;
			end
			tick();
		end
	endtask

	task automatic check_tx(input logic src, input logic trib,
		input logic full, input logic [7:0] rem, input logic [7:0] mask);
		logic [7:0] par;
		logic [7:0] e;
		int i;
		cap_tx();
		par = 8'h00;
		for (i = 0; i < FL; i++) par ^= fa[i];
		check(fb[0], full ? 8'hff : par);
		check(fb[1], full ? 8'hff : 8'h00);
		check(fb[2], (full | src) ? 8'hff : H1);
		check(fb[3], (full | src) ? 8'hff : H2);
		check(fb[4] & mask, rem);
		for (i = 5; i < FL; i++) begin
			e = (full | src | (trib && i >= TF && i <= TL)) ? 8'hff : tx_payload;
			check(fb[i], e);
		end
	endtask

	task automatic t_reset;
		sys_rst = 1'b1;
		repeat (20) tick();
		check(near_end_errors, 16'h0);
		check(server_signal_fail, 1'b0);
		sys_rst = 1'b0;
		tick();
		check(tx_sof, 1'b1);
		check(tx_data, 8'h00);
		run = 1'b1;
		$display("test reset done");
	endtask

	task automatic t_errors;
		logic [15:0] n0;
		logic [15:0] f0;
		logic [15:0] v;
		logic [15:0] t;
		logic [15:0] s;
		err_mask = 8'h05;
		remote_error_indicator = 4'h3;
		remote_defect_indicator = 1'b1;
		wait_frames(3);
		n0 = near_end_errors;
		f0 = far_end_errors;
		v = 16'h0;
		t = 16'h0;
		s = 16'h0;
		repeat (FL) begin
			tick();
			if (code_violation === 1'b1) v++;
			if (rx_out_sof === 1'b1) s++;
			if (tap_violation === 1'b1) t++;
		end
		check(near_end_errors - n0, 16'h2);
		check(v, 16'h1);
		check(t, 16'h0);
		check(far_end_errors - f0, 16'h3);
		check(far_end_defect, 1'b1);
		check(fault_located, 1'b1);
		check(near_end_defect, 1'b0);
		check(s, 16'h1);
		check(rx_out_valid, 1'b1);
		check_tx(1'b0, 1'b0, 1'b0, 8'h02, 8'h8f);
		// upstream tap disturbed too: fault no longer between tap and sink
		tap_err_mask = 8'h01;
		wait_frames(3);
		t = 16'h0;
		repeat (FL) begin
			tick();
			if (tap_violation === 1'b1) t++;
		end
		check(t, 16'h1);
		check(fault_located, 1'b0);
		tap_err_mask = 8'h00;
		err_mask = 8'h00;
		remote_error_indicator = 4'h0;
		remote_defect_indicator = 1'b0;
		wait_frames(3);
		n0 = near_end_errors;
		wait_frames(1);
		check(near_end_errors - n0, 16'h0);
		check(fault_located, 1'b0);
		check(far_end_defect, 1'b0);
		$display("test errors done");
	endtask

	task automatic t_lof;
		int i;
		loss_of_frame_defect = 1'b1;
		tick();
		tick();
		for (i = 0; i < 8; i++) begin
			check(rx_out_data, 8'hff);
			check(server_signal_fail, 1'b1);
			tick();
		end
		check(near_end_defect, 1'b1);
		check_tx(1'b0, 1'b0, 1'b0, 8'h80, 8'h80);
		loss_of_frame_defect = 1'b0;
		repeat (3) tick();
		check(server_signal_fail, 1'b0);
		check(near_end_defect, 1'b0);
		$display("test loss of frame done");
	endtask

	task automatic t_k2;
		k2_alarm = 1'b1;
		wait_frames(2);
		check(ms_alarm_defect, 1'b1);
		check(rx_out_data, 8'hff);
		check(server_signal_fail, 1'b1);
		through_connect = 1'b1;
		check_tx(1'b1, 1'b0, 1'b0, 8'h80, 8'h80);
		through_connect = 1'b0;
		k2_alarm = 1'b0;
		wait_frames(2);
		check(ms_alarm_defect, 1'b0);
		check(server_signal_fail, 1'b0);
		$display("test protection alarm done");
	endtask

	task automatic t_ptr;
		ptr_mode = 2'h1;
		wait_frames(2);
		check(admin_unit_alarm_defect, 1'b1);
		check(rx_out_data, 8'hff);
		check(loss_of_pointer, 1'b0);
		check(tandem_unavailable, 1'b1);
		ptr_mode = 2'h2;
		wait_frames(2);
		check(admin_unit_alarm_defect, 1'b0);
		check(loss_of_pointer, 1'b1);
		check(tandem_unavailable, 1'b1);
		check(server_signal_fail, 1'b0);
		ptr_mode = 2'h0;
		wait_frames(2);
		check(loss_of_pointer, 1'b0);
		check(tandem_unavailable, 1'b0);
		$display("test pointer done");
	endtask

	task automatic t_src;
		tx_alarm_in = 1'b1;
		check_tx(1'b0, 1'b0, 1'b0, 8'h00, 8'h80);
		tx_ssf_in = 1'b1;
		check_tx(1'b1, 1'b0, 1'b0, 8'h00, 8'h80);
		tx_alarm_in = 1'b0;
		tx_ssf_in = 1'b0;
		trib_alarm_in = 1'b1;
		check_tx(1'b0, 1'b1, 1'b0, 8'h00, 8'h80);
		trib_alarm_in = 1'b0;
		pdh_full_alarm = 1'b1;
		check_tx(1'b0, 1'b0, 1'b1, 8'hff, 8'hff);
		pdh_full_alarm = 1'b0;
		$display("test source alarms done");
	endtask

	initial begin
		t_reset();
		t_errors();
		t_lof();
		t_k2();
		t_ptr();
		t_reset();
		t_src();
		end_of_test();
	end
endmodule
`default_nettype wire
